// file: regulator_three_pkg.sv
// Purpose : constants and carriers for the regulator_three control registers
// Assumes : registers are word-indexed; byte address is four times the index
// Notes   : shared by the register bank and its bench
package regulator_three_pkg;

    // -------------------------------------------------------------------------
    // register indices and field layout
    // -------------------------------------------------------------------------
    localparam logic [15:0] GENERAL_CONTROL_INDEX       = 16'h406E;
    localparam logic [15:0] ACTIVE_STATE_CONTROL_INDEX  = 16'h406F;
    localparam logic [15:0] SLEEP_STATE_CONTROL_INDEX   = 16'h4070;
    localparam int          SLOT_LSB                    = 13;
    localparam int          MODE_BIT                    = 8;
    localparam int          HW_VSRC_BIT                 = 10;
    localparam logic [15:0] SLOT_MODE_VCODE_MASK        = 16'hE11F;
    localparam logic [15:0] GENERAL_CONTROL_MASK        = 16'h0400;

    // -------------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------------
    localparam logic [2:0]  ACTIVE_SLOT_RESET           = 3'h0;
    localparam logic        ACTIVE_MODE_RESET           = 1'b0;
    localparam logic [4:0]  ACTIVE_VCODE_RESET          = 5'h00;
    localparam logic [2:0]  SLEEP_SLOT_RESET            = 3'h0;
    localparam logic        SLEEP_MODE_RESET            = 1'b1;
    localparam logic [4:0]  SLEEP_VCODE_RESET           = 5'h00;
    localparam logic        HW_VSRC_RESET               = 1'b0;

    // -------------------------------------------------------------------------
    // slot codes and voltage table
    // -------------------------------------------------------------------------
    localparam logic [2:0]  SLOT_NONE                   = 3'h0;
    localparam logic [2:0]  SLOT_HW_ENABLE_1            = 3'h6;
    localparam logic [2:0]  SLOT_HW_ENABLE_2            = 3'h7;
    localparam logic [2:0]  SLEEP_CODE_SLOT_5           = 3'h0;
    localparam logic [2:0]  SLEEP_CODE_SLOT_3           = 3'h6;
    localparam logic [2:0]  SLEEP_CODE_SLOT_1           = 3'h7;
    localparam logic [2:0]  SLEEP_DISABLE_BASE          = 3'h6;
    localparam logic [4:0]  VCODE_FINE_LAST             = 5'h0E;
    localparam logic [11:0] VOLT_FINE_BASE_MV           = 12'h384;
    localparam logic [11:0] VOLT_FINE_STEP_MV           = 12'h032;
    localparam logic [11:0] VOLT_COARSE_BASE_MV         = 12'h6A4;
    localparam logic [11:0] VOLT_COARSE_STEP_MV         = 12'h064;

    localparam logic [1:0]  RESP_OKAY                   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR                 = 2'h2;

    // sequencer view: current timeslot and one-cycle strobes
    typedef struct packed {
        logic       up_strobe;
        logic       down_strobe;
        logic [2:0] timeslot;
    } sequencer_t;

    // what the regulator is told to do
    typedef struct packed {
        logic        enable;
        logic        low_power;
        logic [4:0]  voltage_code;
        logic [11:0] millivolts;
    } regulator_cmd_t;

endpackage

// file: regulator_on_sleep_control_regs.sv
// Purpose : control registers for regulator_three: start-up slot, sleep entry,
//           mode and voltage for the active and sleep states, AXI4-Lite slave
// Assumes : sequencer strobes and hardware enable inputs are synchronous to aclk
// Notes   : regulator command outputs lag their cause by one clock; sleep-entry and wake mode and voltage lag the strobe by two
//
// Notes on behaviour
// - active slot 000 never enables; 001..101 enable in start-up timeslot 1..5.
// - active slot 110 follows hardware enable 1, 111 follows hardware enable 2.
// - active mode bit 8 picks normal when clear, low power when set.
// - voltage codes 00h..0Eh give 0.90V..1.60V in 50mV steps.
// - codes 0Fh..1Fh give 1.70V..3.30V in 100mV steps, shared table.
// - sleep slot 000/110/111 move to sleep settings in timeslot 5/3/1.
// - sleep slot 001..101 disable the regulator in timeslot 5 down to 1.
// - with hardware enable assigned, codes 001..101 pick sleep-entry slot instead.
// - sleep mode bit 8, reset 1, normal when clear, low power when set.
// - sleep voltage code bits 4:0 use the same table for the sleep state.
// - under hardware control, source bit 10 picks active or sleep voltage code.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module regulator_on_sleep_control_regs #(
    parameter int ADDR_W = 20
) (
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    input  wire logic [ADDR_W-1:0]                    s_axi_awaddr,
    input  wire logic [2:0]                           s_axi_awprot,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [31:0]                          s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]                    s_axi_araddr,
    input  wire logic [2:0]                           s_axi_arprot,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [31:0]                               s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    input  wire regulator_three_pkg::sequencer_t      sequencer,
    input  wire logic                                 hw_enable_1,
    input  wire logic                                 hw_enable_2,
    input  wire logic                                 hw_control_active,
    output regulator_three_pkg::regulator_cmd_t       regulator_cmd
);

    // -------------------------------------------------------------------------
    // register fields
    // -------------------------------------------------------------------------
    logic [2:0]        active_enable_slot;
    logic              active_operating_mode;
    logic [4:0]        active_voltage_code;
    logic [2:0]        sleep_entry_slot;
    logic              sleep_operating_mode;
    logic [4:0]        sleep_voltage_code;
    logic              hw_control_voltage_source;
    logic              in_sleep;

    // shared voltage table: fine steps then coarse steps
    function automatic logic [11:0] code_to_mv(input logic [4:0] code);
        logic [11:0] wide;
        wide = {7'h00, code};
        if (code <= regulator_three_pkg::VCODE_FINE_LAST) begin
            code_to_mv = regulator_three_pkg::VOLT_FINE_BASE_MV
                       + 12'(wide * regulator_three_pkg::VOLT_FINE_STEP_MV);
        end else begin
            code_to_mv = regulator_three_pkg::VOLT_COARSE_BASE_MV
                       + 12'((wide - 12'h00F) * regulator_three_pkg::VOLT_COARSE_STEP_MV);
        end
    endfunction

    // timeslot in which the sleep setting or disable happens
    function automatic logic [2:0] sleep_timeslot(input logic [2:0] code);
        case (code)
            regulator_three_pkg::SLEEP_CODE_SLOT_5: sleep_timeslot = 3'h5;
            regulator_three_pkg::SLEEP_CODE_SLOT_3: sleep_timeslot = 3'h3;
            regulator_three_pkg::SLEEP_CODE_SLOT_1: sleep_timeslot = 3'h1;
            default: sleep_timeslot = regulator_three_pkg::SLEEP_DISABLE_BASE - code;
        endcase
    endfunction

    function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = 16'(addr >> 2);
    endfunction

    // -------------------------------------------------------------------------
    // write channel: address and data taken in either order
    // -------------------------------------------------------------------------
    logic              aw_held;
    logic              w_held;
    logic [15:0]       aw_index;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              write_fire;
    logic              write_hit;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign write_fire    = aw_held && w_held;
    assign write_hit     = aw_index == regulator_three_pkg::GENERAL_CONTROL_INDEX
                        || aw_index == regulator_three_pkg::ACTIVE_STATE_CONTROL_INDEX
                        || aw_index == regulator_three_pkg::SLEEP_STATE_CONTROL_INDEX;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_index     <= 16'h0000;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= regulator_three_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held  <= 1'b1;
                aw_index <= word_index(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (write_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= write_hit ? regulator_three_pkg::RESP_OKAY
                                          : regulator_three_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // register storage; byte lanes 0 and 1 only, undefined bits not stored
    // -------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_enable_slot        <= regulator_three_pkg::ACTIVE_SLOT_RESET;
            active_operating_mode     <= regulator_three_pkg::ACTIVE_MODE_RESET;
            active_voltage_code       <= regulator_three_pkg::ACTIVE_VCODE_RESET;
            sleep_entry_slot          <= regulator_three_pkg::SLEEP_SLOT_RESET;
            sleep_operating_mode      <= regulator_three_pkg::SLEEP_MODE_RESET;
            sleep_voltage_code        <= regulator_three_pkg::SLEEP_VCODE_RESET;
            hw_control_voltage_source <= regulator_three_pkg::HW_VSRC_RESET;
        end else if (write_fire) begin
            case (aw_index)
                regulator_three_pkg::ACTIVE_STATE_CONTROL_INDEX: begin
                    if (w_strb[1]) begin
                        active_enable_slot    <= w_data[15:13];
                        active_operating_mode <= w_data[regulator_three_pkg::MODE_BIT];
                    end
                    if (w_strb[0]) begin
                        active_voltage_code <= w_data[4:0];
                    end
                end
                regulator_three_pkg::SLEEP_STATE_CONTROL_INDEX: begin
                    if (w_strb[1]) begin
                        sleep_entry_slot     <= w_data[15:13];
                        sleep_operating_mode <= w_data[regulator_three_pkg::MODE_BIT];
                    end
                    if (w_strb[0]) begin
                        sleep_voltage_code <= w_data[4:0];
                    end
                end
                regulator_three_pkg::GENERAL_CONTROL_INDEX: begin
                    if (w_strb[1]) begin
                        hw_control_voltage_source <= w_data[regulator_three_pkg::HW_VSRC_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------------------
    logic [15:0]       rd_index;
    logic [15:0]       rd_word;
    logic              rd_hit;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_index      = word_index(s_axi_araddr);

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 16'h0000;
        case (rd_index)
            regulator_three_pkg::ACTIVE_STATE_CONTROL_INDEX:
                rd_word = {active_enable_slot, 4'h0, active_operating_mode,
                           3'h0, active_voltage_code};
            regulator_three_pkg::SLEEP_STATE_CONTROL_INDEX:
                rd_word = {sleep_entry_slot, 4'h0, sleep_operating_mode,
                           3'h0, sleep_voltage_code};
            regulator_three_pkg::GENERAL_CONTROL_INDEX:
                rd_word = {5'h00, hw_control_voltage_source, 10'h000};
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= regulator_three_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_word};
            s_axi_rresp  <= rd_hit ? regulator_three_pkg::RESP_OKAY
                                   : regulator_three_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // sequencing: enable and sleep state
    // -------------------------------------------------------------------------
    logic              hw_assigned;
    logic              hw_level;
    logic              startup_hit;
    logic              sleep_hit;
    logic              sleep_disables;
    logic [2:0]        wake_slot;
    logic              enable_level;

    assign hw_assigned    = active_enable_slot == regulator_three_pkg::SLOT_HW_ENABLE_1
                         || active_enable_slot == regulator_three_pkg::SLOT_HW_ENABLE_2;
    assign hw_level       = (active_enable_slot == regulator_three_pkg::SLOT_HW_ENABLE_1)
                          ? hw_enable_1 : hw_enable_2;
    // under hardware enable the sequencer only wakes it in the first slot
    assign wake_slot      = hw_assigned ? 3'h1 : active_enable_slot;
    assign startup_hit    = sequencer.up_strobe && sequencer.timeslot == wake_slot
                         && active_enable_slot != regulator_three_pkg::SLOT_NONE;
    assign sleep_hit      = sequencer.down_strobe
                         && sequencer.timeslot == sleep_timeslot(sleep_entry_slot);
    assign sleep_disables = !hw_assigned
                         && sleep_entry_slot != regulator_three_pkg::SLEEP_CODE_SLOT_5
                         && sleep_entry_slot < regulator_three_pkg::SLEEP_CODE_SLOT_3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_level <= 1'b0;
        end else if (hw_assigned) begin
            enable_level <= hw_level;
        end else if (active_enable_slot == regulator_three_pkg::SLOT_NONE) begin
            enable_level <= 1'b0;
        end else if (startup_hit) begin
            enable_level <= 1'b1;
        end else if (sleep_hit && sleep_disables) begin
            enable_level <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_sleep <= 1'b0;
        end else if (startup_hit) begin
            in_sleep <= 1'b0;
        end else if (sleep_hit && !sleep_disables) begin
            in_sleep <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // mode and voltage selection
    // -------------------------------------------------------------------------
    logic [4:0]        next_voltage_code;
    logic              low_power_level;
    logic [4:0]        applied_code;
    logic [11:0]       applied_mv;

    always_comb begin
        if (hw_control_active) begin
            next_voltage_code = hw_control_voltage_source ? sleep_voltage_code
                                                          : active_voltage_code;
        end else begin
            next_voltage_code = in_sleep ? sleep_voltage_code : active_voltage_code;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_power_level <= 1'b0;
            applied_code    <= 5'h00;
            applied_mv      <= regulator_three_pkg::VOLT_FINE_BASE_MV;
        end else begin
            low_power_level <= in_sleep ? sleep_operating_mode
                                        : active_operating_mode;
            applied_code    <= next_voltage_code;
            applied_mv      <= code_to_mv(next_voltage_code);
        end
    end

    // one carrier out, each field straight from its own flip-flop, one driver each
    assign regulator_cmd = '{enable: enable_level, low_power: low_power_level,
                             voltage_code: applied_code, millivolts: applied_mv};

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    hw_enable_one_a: assert property (active_enable_slot == 3'h6 |=>
        regulator_cmd.enable == $past(hw_enable_1)) else $error("enable not following hw 1");
    hw_enable_two_a: assert property (active_enable_slot == 3'h7 |=>
        regulator_cmd.enable == $past(hw_enable_2)) else $error("enable not following hw 2");
    slot_none_a: assert property (active_enable_slot == 3'h0 |=> !regulator_cmd.enable)
        else $error("enabled with slot 000");
    startup_slot_a: assert property (sequencer.up_strobe && !hw_assigned
        && active_enable_slot != 3'h0 && sequencer.timeslot == active_enable_slot
        |=> regulator_cmd.enable) else $error("no enable in start-up slot");
    sleep_disable_a: assert property (sequencer.down_strobe && !startup_hit && !hw_assigned
        && sleep_entry_slot inside {[3'h1:3'h5]}
        && sequencer.timeslot == 3'h6 - sleep_entry_slot
        |=> !regulator_cmd.enable) else $error("no disable in sleep slot");
    sleep_enter_a: assert property (sequencer.down_strobe && !startup_hit
        && sleep_entry_slot == 3'h7 && sequencer.timeslot == 3'h1
        |=> in_sleep ##1 regulator_cmd.low_power == $past(sleep_operating_mode))
        else $error("sleep settings not applied in slot 1");
    fine_volt_a: assert property (regulator_cmd.voltage_code <= 5'h0E |->
        regulator_cmd.millivolts == 12'h384 + 12'h032 * regulator_cmd.voltage_code)
        else $error("fine voltage table wrong");
    coarse_volt_a: assert property (regulator_cmd.voltage_code >= 5'h0F |->
        regulator_cmd.millivolts == 12'h6A4 + 12'h064 * (regulator_cmd.voltage_code - 5'h0F))
        else $error("coarse voltage table wrong");
    hw_vsrc_a: assert property (hw_control_active && hw_control_voltage_source |=>
        regulator_cmd.voltage_code == $past(sleep_voltage_code))
        else $error("hw voltage source ignored");
    reserved_zero_a: assert property (s_axi_rvalid |->
        (s_axi_rdata & ~32'h0000_E51F) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    write_done_c: cover property (write_fire && write_hit ##1 s_axi_bvalid);
    read_done_c: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
    hw_follow_c: cover property (hw_assigned && hw_enable_1 ##1 regulator_cmd.enable);
    sleep_entry_c: cover property (!in_sleep ##1 in_sleep);

endmodule

// file: tb_top.sv
// Purpose : self-checking bench for the regulator_three control registers
// Assumes : AXI4-Lite master tasks sample ready/valid at the falling edge before each rising edge
// Notes   : seeded random data and hardware enable levels, fixed corner cases
`timescale 1ns/1ps
module tb_top;
    // -------------------------------------------------------------------------
    // signals and instance
    // -------------------------------------------------------------------------
    localparam logic [19:0] A_GEN = 20'(regulator_three_pkg::GENERAL_CONTROL_INDEX) << 2;
    localparam logic [19:0] A_ON  = 20'(regulator_three_pkg::ACTIVE_STATE_CONTROL_INDEX) << 2;
    localparam logic [19:0] A_SL  = 20'(regulator_three_pkg::SLEEP_STATE_CONTROL_INDEX) << 2;
    logic                                  aclk, aresetn, awvalid, wvalid, bready;
    logic                                  arvalid, rready, awready, wready, bvalid;
    logic                                  arready, rvalid, hw1, hw2, hwc;
    logic [19:0]                           awaddr, araddr;
    logic [31:0]                           wdata, rdata, rd, d;
    logic [3:0]                            wstrb;
    logic [1:0]                            bresp, rresp, rsp;
    regulator_three_pkg::sequencer_t       seq;
    regulator_three_pkg::regulator_cmd_t   cmd;
    int                                    n_mismatch, checks, seed;
    logic [2:0]                            ta [4] = '{3'h1, 3'h1, 3'h1, 3'h6};
    logic [2:0]                            sc [4] = '{3'h0, 3'h6, 3'h7, 3'h3};
    logic [2:0]                            st [4] = '{3'h5, 3'h3, 3'h1, 3'h3};

    regulator_on_sleep_control_regs #(.ADDR_W(20)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sequencer(seq),
        .hw_enable_1(hw1), .hw_enable_2(hw2), .hw_control_active(hwc),
        .regulator_cmd(cmd));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // -------------------------------------------------------------------------
    // tasks and expectations
    // -------------------------------------------------------------------------
    function automatic logic [11:0] mv(input logic [4:0] c);
        return (c <= 5'h0E) ? 12'h384 + 12'h032 * c : 12'h6A4 + 12'h064 * (c - 5'h0F);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ready is sampled at the falling edge so the taken edge is known without a race
    task automatic wr(input logic [19:0] a, input logic [31:0] v);
        logic ta_s, tw_s, ad, wd, b;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ta_s = awvalid && awready;
            tw_s = wvalid && wready;
            @(posedge aclk);
            if (ta_s) begin ad = 1'b1; awvalid <= 1'b0; end
            if (tw_s) begin wd = 1'b1; wvalid <= 1'b0; end
        end
        bready <= 1'b1;
        do begin @(negedge aclk); b = bvalid; rsp = bresp; @(posedge aclk); end while (!b);
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [19:0] a);
        logic t;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1;
        do begin @(negedge aclk); t = arready; @(posedge aclk); end while (!t);
        arvalid <= 1'b0; rready <= 1'b1;
        do begin @(negedge aclk); t = rvalid; rd = rdata; rsp = rresp; @(posedge aclk); end
        while (!t);
        rready <= 1'b0;
    endtask

    // one-cycle sequencer strobe, then wait for registered mode to settle
    task automatic pulse(input logic up, input logic [2:0] ts);
        @(posedge aclk);
        seq <= '{up, !up, ts};
        @(posedge aclk);
        seq <= '0;
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, hw1, hw2, hwc} = '0;
        {awaddr, araddr, wdata, seq} = '0;
        wstrb = 4'hF;
        seed = $urandom(65);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(A_ON); chk(rd, 32'h0000_0000);
        rdr(A_SL); chk(rd, 32'h0000_0100);
        for (int c = 0; c < 32; c++) begin
            d = $urandom;
            d[4:0] = 5'(c);
            wr(A_ON, d); chk(rsp, 32'h0);
            @(posedge aclk); #1;
            chk(cmd.voltage_code, 32'(c));
            chk(cmd.millivolts, mv(5'(c)));
            chk(cmd.low_power, 32'(d[8]));
            rdr(A_ON); chk(rd, d & 32'h0000_E11F);
        end
        for (int k = 1; k <= 5; k++) begin
            wr(A_ON, 32'(k) << 13); wr(A_SL, 32'(k) << 13);
            pulse(1'b1, 3'((k % 5) + 1)); chk(cmd.enable, 32'h0);
            pulse(1'b1, 3'(k)); chk(cmd.enable, 32'h1);
            pulse(1'b0, 3'(((6 - k) % 5) + 1)); chk(cmd.enable, 32'h1);
            pulse(1'b0, 3'(6 - k)); chk(cmd.enable, 32'h0);
        end
        wr(A_ON, 32'h0);
        pulse(1'b1, 3'($urandom_range(1, 5))); chk(cmd.enable, 32'h0);
        for (int s = 6; s <= 7; s++) begin
            wr(A_ON, 32'(s) << 13);
            repeat (6) begin
                @(posedge aclk); hw1 <= 1'($urandom); hw2 <= 1'($urandom);
                repeat (2) @(posedge aclk); #1;
                chk(cmd.enable, (s == 6) ? hw1 : hw2);
            end
        end
        for (int i = 0; i < 4; i++) begin
            hw1 <= 1'b1;
            wr(A_ON, 32'(ta[i]) << 13); wr(A_SL, (32'(sc[i]) << 13) | 32'h011F);
            pulse(1'b1, 3'h1);
            pulse(1'b0, 3'((st[i] % 5) + 1)); chk(cmd.voltage_code, 32'h0);
            pulse(1'b0, st[i]); chk(cmd.enable, 32'h1);
            chk(cmd.low_power, 32'h1);
            chk(cmd.voltage_code, 32'h1F);
            chk(cmd.millivolts, 32'hCE4);
            pulse(1'b1, 3'h1); chk(cmd.low_power, 32'h0);
            chk(cmd.voltage_code, 32'h0);
        end
        hwc <= 1'b1;
        wr(A_GEN, 32'h400); @(posedge aclk); #1; chk(cmd.voltage_code, 32'h1F);
        wr(A_GEN, 32'h0); @(posedge aclk); #1; chk(cmd.voltage_code, 32'h0);
        hwc <= 1'b0;
        // single byte lanes: the other lane's fields must keep their values
        wstrb <= 4'h1;
        wr(A_SL, 32'h0000_FF05);
        rdr(A_SL);
        chk(rd, 32'h0000_6105);
        wstrb <= 4'h2;
        wr(A_SL, 32'h0000_FFE0);
        rdr(A_SL);
        chk(rd, 32'h0000_E105);
        wstrb <= 4'hF;
        wr(A_SL + 20'h4, 32'hFFFF); chk(rsp, 32'h2);
        rdr(20'h00010); chk(rd, 32'h0); chk(rsp, 32'h2);
        results;
    end

    // whole run is under a thousand cycles; this bound only catches a hang
    initial begin
        #200000;
        n_mismatch++;
        results;
    end
endmodule
